// ==== dtr_cmp_if.sv ====
// carries the threshold compare request and answer between the register file and comparator
`timescale 1ns/1ps
`default_nettype none
interface dtr_cmp_if;
   logic [7:0] threshold_hi;
   logic [7:0] result_hi;
   logic       result_stb;
   logic       warning_flag;
   modport regs (output threshold_hi, output result_hi, output result_stb, input warning_flag);
   modport cmp  (input threshold_hi, input result_hi, input result_stb, output warning_flag);
endinterface : dtr_cmp_if
`default_nettype wire

// ==== dtr_host.sv ====
// host side model issuing byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module dtr_host (
   input  wire logic       i_clk_sys,
   input  wire logic [7:0] i_rd_data,
   input  wire logic       i_rd_valid,
   output logic      [7:0] o_addr = 8'h00,
   output logic            o_wr_en = 1'b0,
   output logic      [7:0] o_wr_data = 8'h00,
   output logic            o_rd_en = 1'b0
);
   // called at a falling edge; ends at one with the strobe low a full cycle
   task wr(input logic [7:0] a, input logic [7:0] d);
      o_addr = a;
      o_wr_data = d;
      o_wr_en = 1'b1;
      @(negedge i_clk_sys);
      o_wr_en = 1'b0;
      // released data is inverted so stale bytes never look valid
      o_wr_data = ~d;
      @(negedge i_clk_sys);
   endtask : wr
   // raw bytes only; scaling them to units is left to the host
   task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      o_addr = a;
      o_rd_en = 1'b1;
      @(negedge i_clk_sys);
      // answer stands here, half a cycle after the edge that took the strobe
      o_rd_en = 1'b0;
      d = i_rd_data;
      v = i_rd_valid;
      @(negedge i_clk_sys);
   endtask : rd
endmodule : dtr_host
`default_nettype wire

// ==== dtr_low_warn_cmp.sv ====
// receive-power low-warning comparator
`timescale 1ns/1ps
`default_nettype none
module dtr_low_warn_cmp (
   input  wire logic i_clk_sys,
   input  wire logic i_rstn,
   dtr_cmp_if.cmp    cmp
);
   import dtr_pkg::*;
   logic warn_ff;
   // compare on each new result; low threshold byte never enters
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         warn_ff <= 1'b0;
      end else if (cmp.result_stb) begin
         warn_ff <= (cmp.result_hi < cmp.threshold_hi);
      end
   end
   assign cmp.warning_flag = warn_ff;
endmodule : dtr_low_warn_cmp
`default_nettype wire

// ==== dtr_pkg.sv ====
// shared constants for the diagnostic threshold and result register block
package dtr_pkg;
   localparam logic [7:0] DTR_OFF_RX_LOW_HI  = 8'h26;
   localparam logic [7:0] DTR_OFF_RX_LOW_LO  = 8'h27;
   localparam logic [7:0] DTR_OFF_CHECKSUM   = 8'h5f;
   localparam logic [7:0] DTR_OFF_TEMP_HI    = 8'h60;
   localparam logic [7:0] DTR_OFF_TEMP_LO    = 8'h61;
   localparam logic [7:0] DTR_OFF_VOLT_HI    = 8'h62;
   localparam logic [7:0] DTR_RESET_BYTE     = 8'h00;
   localparam logic [7:0] DTR_ZERO_BYTE      = 8'h00;
   // access levels presented by the password logic
   typedef enum logic [1:0] {
      DTR_LVL_NONE = 2'h0,
      DTR_LVL_USER = 2'h1,
      DTR_LVL_MFR  = 2'h3
   } dtr_level_e;
endpackage : dtr_pkg

// ==== dtr_regs.sv ====
// diagnostic threshold, checksum and adc result byte registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - threshold high byte at 0x26; warn when rx result high below it.
// - threshold low byte at 0x27, writable, sixteen-bit pair of 0.1 uW.
// - low threshold byte ignored in comparisons; software should keep it zero.
// - checksum byte at 0x5f is plain nonvolatile storage, never computed.
// - checksum writes allowed only at manufacturer access level; reads at user or manufacturer level.
// - at user level checksum is read-only; host writes do not change it.
// - temperature high byte read-only at 0x60.
// - temperature low byte at 0x61 always reads zero, unused for flags.
// - supply voltage high byte read-only at 0x62, 25.6 mV per bit.
// - temperature byte reads zero until the first conversion completes.
// - voltage byte valid after one complete conversion cycle.
module dtr_regs (
   input  wire logic              i_clk_sys,
   input  wire logic              i_rstn,
   input  wire logic [7:0]        i_addr,
   input  wire logic              i_wr_en,
   input  wire logic [7:0]        i_wr_data,
   input  wire logic              i_rd_en,
   output logic      [7:0]        o_rd_data,
   output logic                   o_rd_valid,
   input  wire dtr_pkg::dtr_level_e i_access_level,
   input  wire logic              i_temp_done,
   input  wire logic [7:0]        i_temp_hi,
   input  wire logic              i_volt_done,
   input  wire logic [7:0]        i_volt_hi,
   input  wire logic              i_rx_power_done,
   input  wire logic [7:0]        i_rx_power_result_hi,
   output logic                   o_warning_flag,
   output logic [15:0]            o_rx_power_low_warn
);
   import dtr_pkg::*;

   // host-visible byte registers, plus the internal rx result byte and strobe
   logic [7:0] rx_low_hi_ff;
   logic [7:0] rx_low_lo_ff;
   logic [7:0] checksum_ff;
   logic [7:0] temp_hi_ff;
   logic [7:0] volt_hi_ff;
   logic [7:0] rx_res_hi_ff;
   logic       rx_stb_ff;
   logic [7:0] rd_data_ff;
   logic       rd_valid_ff;
   logic [7:0] nxt_rd_data;
   logic       mfr_level;
   // write strobes decoded once per byte
   logic       wr_thr_hi;
   logic       wr_thr_lo;
   logic       wr_checksum;

   // one offset compare shared by the write strobes
   function automatic logic byte_hit(input logic [7:0] addr, input logic [7:0] offset);
      byte_hit = (addr == offset);
   endfunction : byte_hit

   function automatic logic chk_writable(input dtr_level_e level);
      chk_writable = (level == DTR_LVL_MFR);
   endfunction : chk_writable

   function automatic logic chk_readable(input dtr_level_e level);
      chk_readable = (level != DTR_LVL_NONE);
   endfunction : chk_readable

   // zero a byte unless its access check passes
   function automatic logic [7:0] gate_byte(input logic ok, input logic [7:0] value);
      gate_byte = ok ? value : DTR_ZERO_BYTE;
   endfunction : gate_byte

   dtr_cmp_if cmp_bus ();

   assign mfr_level   = chk_writable(i_access_level);
   assign wr_thr_hi   = i_wr_en && byte_hit(i_addr, DTR_OFF_RX_LOW_HI);
   assign wr_thr_lo   = i_wr_en && byte_hit(i_addr, DTR_OFF_RX_LOW_LO);
   // user-level writes are dropped silently; the host gets no error back
   assign wr_checksum = i_wr_en && byte_hit(i_addr, DTR_OFF_CHECKSUM) && mfr_level;
   // writes to result bytes and unmapped offsets decode to no strobe at all

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rx_low_hi_ff <= DTR_RESET_BYTE;
      end else if (wr_thr_hi) begin
         rx_low_hi_ff <= i_wr_data;
      end
   end

   // low threshold byte
   // kept for the host and o_rx_power_low_warn; nothing on the compare path reads it
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rx_low_lo_ff <= DTR_RESET_BYTE;
      end else if (wr_thr_lo) begin
         rx_low_lo_ff <= i_wr_data;
      end
   end

   // storage image only; nonvolatile commit is done by the memory controller outside
   // plain checksum storage
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         checksum_ff <= DTR_RESET_BYTE;
      end else if (wr_checksum) begin
         checksum_ff <= i_wr_data;
      end
   end

   // temperature after conversion
   // a conversion that never finishes leaves the zero default, read as no data
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         temp_hi_ff <= DTR_RESET_BYTE;
      end else if (i_temp_done) begin
         temp_hi_ff <= i_temp_hi;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         volt_hi_ff <= DTR_RESET_BYTE;
      end else if (i_volt_done) begin
         volt_hi_ff <= i_volt_hi;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rx_res_hi_ff <= DTR_RESET_BYTE;
      end else if (i_rx_power_done) begin
         rx_res_hi_ff <= i_rx_power_result_hi;
      end
   end

   // compare strobe
   // byte and strobe register on one edge, so the comparator reads the new byte
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rx_stb_ff <= 1'b0;
      end else begin
         rx_stb_ff <= i_rx_power_done;
      end
   end

   // only high bytes reach the comparator
   assign cmp_bus.threshold_hi = rx_low_hi_ff;
   assign cmp_bus.result_hi    = rx_res_hi_ff;
   assign cmp_bus.result_stb   = rx_stb_ff;

   dtr_low_warn_cmp u_cmp (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .cmp       (cmp_bus.cmp)
   );

   // read decode; unmapped offsets read zero
   always_comb begin
      nxt_rd_data = DTR_ZERO_BYTE;
      unique case (i_addr)
         DTR_OFF_RX_LOW_HI: begin
            nxt_rd_data = rx_low_hi_ff;
         end
         DTR_OFF_RX_LOW_LO: begin
            nxt_rd_data = rx_low_lo_ff;
         end
         DTR_OFF_CHECKSUM: begin
            nxt_rd_data = gate_byte(chk_readable(i_access_level), checksum_ff);
         end
         DTR_OFF_TEMP_HI: begin
            nxt_rd_data = temp_hi_ff;
         end
         DTR_OFF_TEMP_LO: begin
            nxt_rd_data = DTR_ZERO_BYTE;
         end
         DTR_OFF_VOLT_HI: begin
            nxt_rd_data = volt_hi_ff;
         end
         default: begin
            nxt_rd_data = DTR_ZERO_BYTE;
         end
      endcase
   end

   // read answer pulse, one cycle after the strobe
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rd_valid_ff <= 1'b0;
      end else begin
         rd_valid_ff <= i_rd_en;
      end
   end

   // read byte holds until the next read so a slow host can still pick it up
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rd_data_ff <= DTR_ZERO_BYTE;
      end else if (i_rd_en) begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   // outputs straight from flip-flops
   assign o_rd_data           = rd_data_ff;
   assign o_rd_valid          = rd_valid_ff;
   assign o_warning_flag      = cmp_bus.warning_flag;
   assign o_rx_power_low_warn = {rx_low_hi_ff, rx_low_lo_ff};
endmodule : dtr_regs
`default_nettype wire

// ==== dtr_regs_properties.sv ====
// port assertions for the register block
`timescale 1ns/1ps
`default_nettype none
module dtr_regs_properties (
   input wire logic        i_clk_sys,
   input wire logic        i_rstn,
   input wire logic [7:0]  i_addr,
   input wire logic        i_wr_en,
   input wire logic [7:0]  i_wr_data,
   input wire logic        i_rd_en,
   input wire logic [7:0]  o_rd_data,
   input wire logic        o_rd_valid,
   input wire logic        i_temp_done,
   input wire logic [7:0]  i_temp_hi,
   input wire logic        i_rx_power_done,
   input wire logic [7:0]  i_rx_power_result_hi,
   input wire logic        o_warning_flag,
   input wire logic [15:0] o_rx_power_low_warn
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   // a result with no write in its cycle and no result or write in the next
   sequence rx_sole;
      i_rx_power_done && !i_wr_en ##1 !i_rx_power_done && !i_wr_en;
   endsequence
   // two cycles with no new result
   sequence rx_quiet;
      !i_rx_power_done ##1 !i_rx_power_done;
   endsequence
   // a finished conversion read back at once
   sequence temp_then_read;
      i_temp_done ##1 !i_temp_done && i_rd_en && i_addr == 8'h60;
   endsequence
   a_rd_answer: assert property (i_rd_en |=> o_rd_valid)
      else $error("read answer missing");
   a_rd_quiet: assert property (!i_rd_en |=> !o_rd_valid)
      else $error("read answer without request");
   a_thr_hi_read: assert property (
      i_rd_en && i_addr == 8'h26 |=> o_rd_data == $past(o_rx_power_low_warn[15:8]))
      else $error("threshold read wrong");
   a_thr_hi_write: assert property (
      i_wr_en && i_addr == 8'h26 |=> o_rx_power_low_warn[15:8] == $past(i_wr_data))
      else $error("threshold high not written");
   a_thr_lo_write: assert property (
      i_wr_en && i_addr == 8'h27 |=> o_rx_power_low_warn[7:0] == $past(i_wr_data))
      else $error("threshold low not written");
   a_temp_lo_zero: assert property (i_rd_en && i_addr == 8'h61 |=> o_rd_data == 8'h00)
      else $error("temperature low not zero");
   a_warn_compare: assert property (
      rx_sole |=> o_warning_flag == ($past(i_rx_power_result_hi, 2) < o_rx_power_low_warn[15:8]))
      else $error("warning flag wrong");
   a_warn_holds: assert property (rx_quiet |=> $stable(o_warning_flag))
      else $error("warning flag moved");
   a_temp_capture: assert property (temp_then_read |=> o_rd_data == $past(i_temp_hi, 2))
      else $error("temperature not captured");
endmodule : dtr_regs_properties
bind dtr_regs dtr_regs_properties dtr_regs_properties_i (.*);
`default_nettype wire

// ==== dtr_regs_test.sv ====
// self-checking bench for the register block
`timescale 1ns/1ps
`default_nettype none
module dtr_regs_test;
   import dtr_pkg::*;
   logic        i_clk_sys = 1'b0;
   logic        i_rstn = 1'b0;
   dtr_level_e  lvl = DTR_LVL_MFR;
   logic [7:0]  addr, wr_data, rd_data, d, temp_hi = 8'h00, volt_hi = 8'h00, rx_hi = 8'h00;
   logic        wr_en, rd_en, rd_valid, warn, v;
   logic        temp_done = 1'b0, volt_done = 1'b0, rx_done = 1'b0;
   logic [15:0] thr;
   logic [7:0]  offs [7] = '{8'h26, 8'h27, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h63};
   int          n_mismatch = 0;
   int          check_count = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   dtr_host dtr_host_i (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
      .o_addr(addr), .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en));
   dtr_regs dtr_regs_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(addr), .i_wr_en(wr_en),
      .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
      .i_access_level(lvl), .i_temp_done(temp_done), .i_temp_hi(temp_hi),
      .i_volt_done(volt_done), .i_volt_hi(volt_hi), .i_rx_power_done(rx_done),
      .i_rx_power_result_hi(rx_hi), .o_warning_flag(warn), .o_rx_power_low_warn(thr));
   task chk(input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task rchk(input logic [7:0] a, input logic [7:0] e);
      dtr_host_i.rd(a, d, v);
      chk(d, e);
      chk({7'h00, v}, 8'h01);
   endtask : rchk
   // flag settles two edges after the result strobe
   task rx(input logic [7:0] r);
      rx_hi = r;
      rx_done = 1'b1;
      @(negedge i_clk_sys);
      rx_done = 1'b0;
      repeat (2) @(negedge i_clk_sys);
   endtask : rx
   task close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      repeat (400) @(posedge i_clk_sys);
      n_mismatch++;
      close_out;
   end
   initial begin
      repeat (5) @(negedge i_clk_sys);
      i_rstn = 1'b1;
      foreach (offs[k]) rchk(offs[k], 8'h00);
      $display("reset test done");
      dtr_host_i.wr(8'h26, 8'h80);
      dtr_host_i.wr(8'h27, 8'h12);
      chk(thr[15:8], 8'h80);
      rchk(8'h27, 8'h12);
      rx(8'h7f);
      chk({7'h00, warn}, 8'h01);
      rx(8'h80);
      chk({7'h00, warn}, 8'h00);
      dtr_host_i.wr(8'h26, 8'h81);
      chk({7'h00, warn}, 8'h00);
      rx(8'h80);
      chk({7'h00, warn}, 8'h01);
      $display("threshold test done");
      lvl = DTR_LVL_USER;
      dtr_host_i.wr(8'h5f, 8'haa);
      rchk(8'h5f, 8'h00);
      lvl = DTR_LVL_MFR;
      dtr_host_i.wr(8'h5f, 8'haa);
      rchk(8'h5f, 8'haa);
      lvl = DTR_LVL_NONE;
      rchk(8'h5f, 8'h00);
      lvl = DTR_LVL_USER;
      rchk(8'h5f, 8'haa);
      $display("checksum test done");
      temp_hi = 8'h5a;
      volt_hi = 8'ha5;
      temp_done = 1'b1;
      volt_done = 1'b1;
      @(negedge i_clk_sys);
      temp_done = 1'b0;
      volt_done = 1'b0;
      rchk(8'h60, 8'h5a);
      dtr_host_i.wr(8'h62, 8'h00);
      rchk(8'h62, 8'ha5);
      rchk(8'h61, 8'h00);
      dtr_host_i.wr(8'h63, 8'h33);
      rchk(8'h63, 8'h00);
      $display("result test done");
      close_out;
   end
endmodule : dtr_regs_test
`default_nettype wire
